/* File: design/fwsr_cycle.sv */
`timescale 1ns/10ps
module fwsr_cycle
  import fwsr_pkg::*;
#(
  parameter int STROBE = STROBE_CYC,
  parameter int GAP    = GAP_CYC
) (
  input  wire logic              clk,      // System clock
  input  wire logic              srst,     // Sync reset
  input  wire logic              start,    // Begin a bus cycle
  input  wire logic              isWrite,  // One for write cycle
  input  wire logic [ADDR_W-1:0] addr,     // Cycle address
  input  wire logic [DATA_W-1:0] wdata,    // Write data
  input  wire logic [DATA_W-1:0] pinData,  // Synchronised flash data
  output fwsr_pkg::fwsr_bus_t    bus,      // Flash pins
  output logic                   busy,     // Cycle in progress
  output logic                   done,     // One-cycle end pulse
  output logic [DATA_W-1:0]      rdata     // Captured read data
);
  import fwsr_pkg::*;
  // The phase counter is eight bits wide, so longer strobes cannot be served
  if (STROBE < 1 || GAP < 1 || STROBE > 255 || GAP > 255) begin : g_bad_timing
    $error("bad strobe timing");
  end
  fwsr_bus_t   next_bus;
  logic [7:0]  cnt, next_cnt;
  logic        inGap, next_inGap, next_busy, next_done;
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_bus = bus;
    next_cnt = cnt;
    next_inGap = inGap;
    next_busy = busy;
    next_done = 1'b0;
    next_rdata = rdata;
    if (!busy && start) begin
      next_busy = 1'b1;
      next_inGap = 1'b0;
      next_cnt = 8'(STROBE - 1);
      next_bus.addr = addr;
      next_bus.dout = wdata;
      next_bus.doutEn = isWrite;
      next_bus.ceN = 1'b0;
      next_bus.oeN = isWrite;
      next_bus.weN = !isWrite;
    end else if (busy && cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end else if (busy && !inGap) begin
      // Sample late in the strobe; strobe release ends the read cycle for the device
      if (!bus.oeN) next_rdata = pinData;
      next_bus.oeN = 1'b1;
      next_bus.weN = 1'b1;
      next_bus.ceN = 1'b1;
      next_inGap = 1'b1;
      next_cnt = 8'(GAP - 1);
    end else if (busy) begin
      next_bus.doutEn = 1'b0;
      next_busy = 1'b0;
      next_done = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      bus <= '{addr: '0, dout: '0, doutEn: 1'b0, ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
      cnt <= 8'h00;
      inGap <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      bus <= next_bus;
      cnt <= next_cnt;
      inGap <= next_inGap;
      busy <= next_busy;
      done <= next_done;
      rdata <= next_rdata;
    end
  end
  chk_one_strobe: assert property (@(posedge clk) disable iff (srst)
    !(!bus.oeN && !bus.weN)) else $error("read and write strobes together");
endmodule

/* File: design/fwsr_pkg.sv */
package fwsr_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [7:0] RESET_CMD = 8'hF0;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 17'h00000;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LIMIT_BIT = 5;
  localparam int TIMER_BIT = 3;
  localparam int SECTOR_BIT = 2;
  localparam int CLK_MHZ = 40;
  localparam int T_STROBE_NS = 100;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_GAP_NS = 50;
  localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] RES_DONE = 2'h0;
  localparam logic [1:0] RES_FAIL = 2'h1;
  localparam logic [1:0] RES_SUSP = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              doutEn;
    logic              ceN;
    logic              oeN;
    logic              weN;
  } fwsr_bus_t;

  typedef struct packed {
    logic       done;
    logic [1:0] code;
    logic [7:0] data;
  } fwsr_result_t;
endpackage

/* File: design/fwsr_poll.sv */
`timescale 1ns/10ps
// Operation
// [R1] Polarity bit valid only after last write strobe; we poll after the command.
// [R2] During program polarity bit shows inverse of bit 7 until done.
// [R3] Host reads status at the programmed address.
// [R4] Protected program shows status about 2 us then array data.
// [R5] Erase shows polarity zero, one when done or suspended.
// [R6] Host reads erase status inside a selected sector.
// [R7] All-protected erase shows status about 100 us then array data.
// [R8] Partially protected erase skips protected sectors silently.
// [R9] After polarity turns true, host takes byte data on a later read.
// [R10] First toggle bit readable anywhere after last write strobe.
// [R11] First toggle bit inverts each read while operation runs.
// [R12] First toggle bit stops inverting in erase suspend.
// [R13] First toggle bit toggles again during suspend programming.
// [R14] Second toggle bit inverts on reads to erasing sectors.
// [R15] Host reads twice, compares toggle; no change means finished.
// [R16] Toggling with limit bit high: recheck; still toggling means failure, reset.
// [R17] Host restarts with a double read after leaving monitoring.
// [R18] Limit bit high means program or erase failed.
// [R19] Programming zero to one halts and raises the limit bit.
// [R20] After limit failure host sends the reset command.
// [R21] Reset command is one write of F0 at any address.
// [R22] Erase timer bit zero while sectors may be added, then one.
// [R23] Toggle advances once per read cycle.
module fwsr_poll
  import fwsr_pkg::*;
#(
  parameter int STROBE = STROBE_CYC,
  parameter int GAP    = GAP_CYC
) (
  input  wire logic              clk,        // System clock
  input  wire logic              srst,       // Sync reset
  input  wire logic              start,      // Start a status check
  input  wire logic              useData,    // One: polarity polling, zero: toggle polling
  input  wire logic              isErase,    // Operation is an erase
  input  wire logic [ADDR_W-1:0] statusAddr, // Programmed address or selected-sector address
  input  wire logic [DATA_W-1:0] expData,    // Programmed byte
  output logic                   ready,      // Idle, accepts start
  output fwsr_pkg::fwsr_result_t result,     // Outcome, done is a pulse
  output fwsr_pkg::fwsr_bus_t    bus,        // Flash control pins
  input  wire logic [DATA_W-1:0] dqIn        // Flash data pins
);
  import fwsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: stage one feeds stage two only
  logic [DATA_W-1:0] dqMeta, dqSync;
  always_ff @(posedge clk) begin
    if (srst) begin
      dqMeta <= 8'h00;
      dqSync <= 8'h00;
    end else begin
      dqMeta <= dqIn;
      dqSync <= dqMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    FWSR_IDLE  = 3'b000,
    FWSR_RD1   = 3'b001,
    FWSR_RD2   = 3'b011,
    FWSR_CHK   = 3'b010,
    FWSR_FINAL = 3'b110,
    FWSR_RST   = 3'b111,
    FWSR_FIN   = 3'b100
  } fwsr_state_t;

  fwsr_state_t state, next_state;
  logic        cycStart, cycWrite, cycBusy, cycDone;
  logic [ADDR_W-1:0] cycAddr, opAddr, next_opAddr;
  logic [DATA_W-1:0] cycWdata, cycRdata, firstRd, next_firstRd, expByte, next_expByte;
  logic        dataMode, next_dataMode, eraseOp, next_eraseOp;
  logic        limitSeen, next_limitSeen, issued, next_issued;
  logic [3:0]  readCnt, next_readCnt;
  logic        rstSent, next_rstSent;
  fwsr_result_t next_result;

  fwsr_cycle #(.STROBE(STROBE), .GAP(GAP)) u_cycle (
    .clk     (clk),
    .srst    (srst),
    .start   (cycStart),
    .isWrite (cycWrite),
    .addr    (cycAddr),
    .wdata   (cycWdata),
    .pinData (dqSync),
    .bus     (bus),
    .busy    (cycBusy),
    .done    (cycDone),
    .rdata   (cycRdata)
  );

  // True when the polarity bit shows its expected value for a finished operation
  function automatic logic pollTrue(input logic erase, input logic [7:0] exp, input logic [7:0] rd);
    pollTrue = erase ? rd[POLL_BIT] : (rd[POLL_BIT] == exp[POLL_BIT]); // R2 R5
  endfunction

  assign ready = (state == FWSR_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_opAddr = opAddr;
    next_firstRd = firstRd;
    next_expByte = expByte;
    next_dataMode = dataMode;
    next_eraseOp = eraseOp;
    next_limitSeen = limitSeen;
    next_issued = issued;
    next_result = result;
    next_result.done = 1'b0;
    cycStart = 1'b0;
    cycWrite = 1'b0;
    cycAddr = opAddr; // R3 R6
    cycWdata = 8'h00;
    next_readCnt = readCnt;
    next_rstSent = rstSent;
    // Bookkeeping for the checks below only: completed reads and a sent reset command
    if (cycDone && state != FWSR_RST && readCnt != 4'hF) next_readCnt = readCnt + 4'h1;
    if (!bus.weN && bus.dout == RESET_CMD) next_rstSent = 1'b1;
    case (state)
      FWSR_IDLE: begin
        if (start) begin
          // R1 R10 R17: every check starts afresh with a first read
          next_opAddr = statusAddr;
          next_expByte = expData;
          next_dataMode = useData;
          next_eraseOp = isErase;
          next_limitSeen = 1'b0;
          next_issued = 1'b0;
          next_readCnt = 4'h0;
          next_rstSent = 1'b0;
          next_state = FWSR_RD1;
        end
      end
      FWSR_RD1: begin
        cycStart = !issued && !cycBusy;
        if (cycStart) next_issued = 1'b1;
        if (cycDone) begin
          next_firstRd = cycRdata;
          next_issued = 1'b0;
          next_state = FWSR_RD2; // R15
        end
      end
      FWSR_RD2: begin
        cycStart = !issued && !cycBusy;
        if (cycStart) next_issued = 1'b1;
        if (cycDone) begin
          next_issued = 1'b0;
          next_state = FWSR_CHK;
        end
      end
      FWSR_CHK: begin
        if (dataMode ? pollTrue(eraseOp, expByte, cycRdata)
                     : (cycRdata[TOGGLE_BIT] == firstRd[TOGGLE_BIT])) begin // R11 R23
          // R9: the byte returned is from the read after the one that showed completion
          next_state = FWSR_FINAL;
        end else if (limitSeen) begin
          next_state = FWSR_RST; // R16 R18 R19 R20
        end else if (cycRdata[LIMIT_BIT]) begin
          next_limitSeen = 1'b1; // R16: recheck once more
          next_firstRd = cycRdata;
          next_state = FWSR_RD2;
        end else begin
          next_firstRd = cycRdata;
          next_state = FWSR_RD2;
        end
        // The first toggle bit alone does not spot suspend; erase in suspend reports through the sector bit
        if (!dataMode && eraseOp && cycRdata[TOGGLE_BIT] == firstRd[TOGGLE_BIT]
            && cycRdata[SECTOR_BIT] != firstRd[SECTOR_BIT]) begin // R12 R14
          next_result.code = RES_SUSP;
          next_result.data = cycRdata;
          next_state = FWSR_FIN;
        end
      end
      FWSR_FINAL: begin
        cycStart = !issued && !cycBusy;
        if (cycStart) next_issued = 1'b1;
        if (cycDone) begin
          next_result.code = RES_DONE;
          next_result.data = cycRdata;
          next_state = FWSR_FIN;
        end
      end
      FWSR_RST: begin
        cycStart = !issued && !cycBusy;
        cycWrite = 1'b1;
        cycAddr = RESET_ADDR;
        cycWdata = RESET_CMD; // R21
        if (cycStart) next_issued = 1'b1;
        if (cycDone) begin
          next_result.code = RES_FAIL;
          next_result.data = firstRd;
          next_state = FWSR_FIN;
        end
      end
      FWSR_FIN: begin
        next_result.done = 1'b1;
        next_issued = 1'b0;
        next_state = FWSR_IDLE;
      end
      default: next_state = FWSR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= FWSR_IDLE;
      opAddr <= '0;
      firstRd <= 8'h00;
      expByte <= 8'h00;
      dataMode <= 1'b0;
      eraseOp <= 1'b0;
      limitSeen <= 1'b0;
      issued <= 1'b0;
      readCnt <= 4'h0;
      rstSent <= 1'b0;
      result <= '0;
    end else begin
      state <= next_state;
      opAddr <= next_opAddr;
      firstRd <= next_firstRd;
      expByte <= next_expByte;
      dataMode <= next_dataMode;
      eraseOp <= next_eraseOp;
      limitSeen <= next_limitSeen;
      issued <= next_issued;
      readCnt <= next_readCnt;
      rstSent <= next_rstSent;
      result <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_status_address: assert property (@(posedge clk) disable iff (srst) // R3
    (!bus.oeN && state != FWSR_RST) |-> bus.addr == opAddr) else $error("status read at wrong address");
  chk_reset_value: assert property (@(posedge clk) disable iff (srst) // R21
    (!bus.weN) |-> (bus.dout == RESET_CMD && bus.doutEn)) else $error("reset write not F0");
  chk_fail_reset: assert property (@(posedge clk) disable iff (srst) // R20
    (result.done && result.code == RES_FAIL) |-> rstSent) else $error("fail without reset");
  chk_two_reads: assert property (@(posedge clk) disable iff (srst) // R15
    result.done |-> readCnt >= 4'h2) else $error("outcome after fewer than two reads");
  chk_fail_needs_limit: assert property (@(posedge clk) disable iff (srst) // R16
    (state == FWSR_CHK && next_state == FWSR_RST) |-> limitSeen) else $error("reset without limit recheck");
  chk_double_read: assert property (@(posedge clk) disable iff (srst) // R15
    (state == FWSR_IDLE && start) |=> state == FWSR_RD1) else $error("check did not start with a first read");
  chk_done_pulse: assert property (@(posedge clk) disable iff (srst)
    result.done |=> !result.done) else $error("done longer than one cycle");
endmodule

/* File: verification/fwsr_flash_model.sv */
`timescale 1ns/10ps
module fwsr_flash_model
  import fwsr_pkg::*;
(
  input  wire logic          load,     // New operation begins
  input  wire logic [1:0]    kind,     // 0 program, 1 erase, 2 suspended, 3 failing
  input  wire logic [7:0]    reads,    // Status reads before completion
  input  wire logic [7:0]    pdata,    // Programmed byte or erased value
  input  fwsr_pkg::fwsr_bus_t bus,     // Controller pins
  output logic [DATA_W-1:0]  dq,       // Data pins
  output logic [ADDR_W-1:0]  lastAddr, // Address of last status read
  output logic               failed    // Limit failure still latched
);
  logic              rdEnd;
  logic              wrEnd;
  logic              tog;
  logic              sec;
  logic              active;
  logic [7:0]        cnt;
  logic [7:0]        stat;
  logic [7:0]        last;
  logic [7:0]        wdat;
  logic [ADDR_W-1:0] rdAddr;
  ////////////////////////////////////////////////////////////////////////////
  assign rdEnd = bus.ceN | bus.oeN;
  assign wrEnd = bus.ceN | bus.weN;
  assign active = failed || kind == 2'h2 || cnt != 8'h00;
  initial begin
    failed = 1'b0;
    cnt = 8'h00;
    tog = 1'b0;
    sec = 1'b0;
    last = 8'h00;
  end
  // Status starts at the final command strobe, modelled by load
  always @(posedge load) begin
    cnt = reads;
    tog = 1'b0;
    sec = 1'b0;
    failed = (kind == 2'h3);
  end
  always @(posedge rdEnd) begin
    if (active) begin
      lastAddr = rdAddr;
      if (kind != 2'h2) tog = ~tog;
      sec = ~sec;
      if (cnt != 8'h00) cnt = cnt - 8'h01;
    end
  end
  always @(posedge wrEnd) begin
    if (wdat == RESET_CMD) begin
      failed = 1'b0;
      cnt = 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (kind)
      2'h0: stat = {~pdata[7], tog, 6'h00};
      2'h1: stat = {1'b0, tog, 2'h0, 1'b1, sec, 2'h0};
      2'h2: stat = {1'b1, tog, 3'h0, sec, 2'h0};
      default: stat = {~pdata[7], tog, 1'b1, 5'h00};
    endcase
    if (!active) stat = pdata;
  end
  // Released pins show the inverse so a stale sample cannot pass
  always @(bus or stat) begin
    if (!bus.ceN && !bus.oeN) begin
      last = stat;
      rdAddr = bus.addr;
      dq = stat;
    end else begin
      dq = ~last;
    end
    if (!bus.ceN && !bus.weN) wdat = bus.dout;
  end
endmodule

/* File: verification/tb_fwsr_poll.sv */
`timescale 1ns/10ps
module tb_fwsr_poll;
  import fwsr_pkg::*;
  logic              clk;
  logic              srst;
  logic              start;
  logic              useData;
  logic              isErase;
  logic              load;
  logic              ready;
  logic              failed;
  logic [1:0]        kind;
  logic [7:0]        reads;
  logic [7:0]        pdata;
  logic [DATA_W-1:0] expData;
  logic [DATA_W-1:0] dq;
  logic [ADDR_W-1:0] statusAddr;
  logic [ADDR_W-1:0] lastAddr;
  fwsr_result_t      result;
  fwsr_bus_t         bus;
  int                err_count;
  int                checked;
  ////////////////////////////////////////////////////////////////////////////
  fwsr_poll dut (.clk(clk), .srst(srst), .start(start), .useData(useData), .isErase(isErase),
    .statusAddr(statusAddr), .expData(expData), .ready(ready), .result(result), .bus(bus), .dqIn(dq));
  fwsr_flash_model flash (.load(load), .kind(kind), .reads(reads), .pdata(pdata), .bus(bus), .dq(dq),
    .lastAddr(lastAddr), .failed(failed));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic op(input logic [1:0] k, input logic [7:0] n, input logic ud, input logic er,
                    input logic [7:0] pd, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    #2;
    kind = k;
    reads = n;
    pdata = pd;
    expData = pd;
    useData = ud;
    isErase = er;
    statusAddr = a;
    load = 1'b1;
    start = 1'b1;
    @(posedge clk);
    #2;
    start = 1'b0;
    load = 1'b0;
    for (int i = 0; i < 3000 && result.done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (result.done !== 1'b1) begin
      err_count++;
      results();
    end
    check("ready", ADDR_W'(ready), 17'h00001);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic progPoll;
    op(2'h0, 8'h03, 1'b1, 1'b0, 8'hA5, 17'h1ABCD);
    check("code", ADDR_W'(result.code), ADDR_W'(RES_DONE));
    check("data", ADDR_W'(result.data), 17'h000A5);
    check("addr", lastAddr, 17'h1ABCD);
    $display("program polarity test done");
  endtask
  task automatic progToggle;
    op(2'h0, 8'h04, 1'b0, 1'b0, 8'h3C, 17'h00123);
    check("code", ADDR_W'(result.code), ADDR_W'(RES_DONE));
    check("data", ADDR_W'(result.data), 17'h0003C);
    $display("program toggle test done");
  endtask
  task automatic eraseToggle;
    op(2'h1, 8'h05, 1'b0, 1'b1, 8'hFF, 17'h1C000);
    check("code", ADDR_W'(result.code), ADDR_W'(RES_DONE));
    check("addr", lastAddr, 17'h1C000);
    $display("erase toggle test done");
  endtask
  task automatic erasePoll;
    op(2'h1, 8'h03, 1'b1, 1'b1, 8'hFF, 17'h0E000);
    check("code", ADDR_W'(result.code), ADDR_W'(RES_DONE));
    check("data", ADDR_W'(result.data), 17'h000FF);
    $display("erase polarity test done");
  endtask
  task automatic suspendCheck;
    op(2'h2, 8'h00, 1'b0, 1'b1, 8'hFF, 17'h1C010);
    check("code", ADDR_W'(result.code), ADDR_W'(RES_SUSP));
    $display("suspend test done");
  endtask
  task automatic failToggle;
    op(2'h3, 8'h00, 1'b0, 1'b0, 8'h00, 17'h00400);
    check("code", ADDR_W'(result.code), ADDR_W'(RES_FAIL));
    check("failed", ADDR_W'(failed), 17'h00000);
    $display("toggle failure test done");
  endtask
  task automatic failPoll;
    op(2'h3, 8'h00, 1'b1, 1'b0, 8'h80, 17'h00401);
    check("code", ADDR_W'(result.code), ADDR_W'(RES_FAIL));
    check("failed", ADDR_W'(failed), 17'h00000);
    $display("polarity failure test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    start = 1'b0;
    useData = 1'b0;
    isErase = 1'b0;
    load = 1'b0;
    kind = 2'h0;
    reads = 8'h00;
    pdata = 8'h00;
    expData = 8'h00;
    statusAddr = 17'h00000;
    err_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    #2;
    srst = 1'b0;
    progPoll();
    progToggle();
    eraseToggle();
    erasePoll();
    suspendCheck();
    failToggle();
    failPoll();
    results();
  end
endmodule
